// [hdl/gef_gradient_edge_filter.sv]
// Purpose: Streaming 3x3 gradient edge detector with a two-entry output buffer.
// Assumes: Pixels and threshold come from logic on the same clock.
// Notes:   The pipeline only moves when a pixel is accepted.
`timescale 1ns/1ps
`include "gef_params.svh"
module gef_gradient_edge_filter #(
  parameter int LINE_LEN    = `GEF_LINE_LEN,
  parameter int SCALE_SHIFT = `GEF_SCALE_SHIFT
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Pixel input stream.
  input  wire logic                 inValid,
  output logic                      inReady,
  input  wire gef_pkg::gef_pix_t    inPixel,
  // Configuration.
  input  wire gef_pkg::gef_str_t    threshold,
  // Result output stream.
  output logic                      outValid,
  input  wire logic                 outReady,
  output gef_pkg::gef_result_t      outResult
);
  import gef_pkg::*;

  localparam int CW = (LINE_LEN > 1) ? $clog2(LINE_LEN) : 1;

  // ---------------------------------------------------------------
  // Absolute value
  // ---------------------------------------------------------------
  function automatic gef_sum_t absVal(input gef_grad_t v);
    gef_grad_t negV;
    negV = -v;
    absVal = v[`GEF_GRAD_W-1] ? negV[`GEF_SUM_W-1:0] : v[`GEF_SUM_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  gef_pix_t                lineBufA [LINE_LEN];
  gef_pix_t                lineBufB [LINE_LEN];
  logic     [CW-1:0]       col_ff;
  logic                    lineFull_ff;
  logic                    lineTwo_ff;
  logic                    outValid_ff;
  gef_pix_t                winTop_ff [3];
  gef_pix_t                winMid_ff [3];
  gef_pix_t                winBot_ff [3];
  logic                    v0_ff, v1_ff, v2_ff, v3_ff, v4_ff;
  gef_colsum_t             sums_ff;
  gef_grad_t               gradX_ff, gradY_ff;
  gef_sum_t                absX_ff, absY_ff;
  gef_result_t             res_ff;
  gef_str_t                thrQ_ff;
  gef_result_t             head_ff, tail_ff;
  logic     [`GEF_CNT_W-1:0] count_ff;
  logic                    inReady_ff;

  wire                     adv;
  wire                     push;
  wire                     pop;
  wire      [CW-1:0]       nxt_col;
  wire                     colLast;
  wire      gef_pix_t      tapA;
  wire      gef_pix_t      tapB;
  wire      gef_colsum_t   nxt_sums;
  wire      gef_grad_t     nxt_gradX;
  wire      gef_grad_t     nxt_gradY;
  wire      [`GEF_STR_W-1:0] rawStr;
  wire      gef_str_t      scaledStr;
  wire      [`GEF_CNT_W-1:0] nxt_count;
  wire                     headFromPush;
  wire                     headFromTail;
  wire                     tailLoad;

  // ---------------------------------------------------------------
  // Stream handshake
  // ---------------------------------------------------------------
  assign adv  = inValid & inReady_ff;
  assign push = adv & v4_ff;
  assign pop  = (count_ff != 2'h0) & outReady;

  // ---------------------------------------------------------------
  // Line buffers and window
  // ---------------------------------------------------------------
  assign colLast = (col_ff == CW'(LINE_LEN - 1));
  assign nxt_col = colLast ? '0 : col_ff + CW'(1);
  // A tap whose line has not been written yet shows zero. The line memories
  // have no reset, so without this the first lines after any reset would
  // carry stale or unknown pixels into the window.
  assign tapA    = lineFull_ff ? lineBufA[col_ff] : '0;
  assign tapB    = lineTwo_ff ? lineBufB[col_ff] : '0;

  always_ff @(posedge clk) begin
    if (adv) begin
      lineBufA[col_ff] <= inPixel;
      lineBufB[col_ff] <= tapA;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_ff      <= '0;
      lineFull_ff <= 1'b0;
      lineTwo_ff  <= 1'b0;
    end else if (adv) begin
      col_ff      <= nxt_col;
      lineFull_ff <= lineFull_ff | colLast;
      // Second line complete: the older line memory now holds real pixels.
      lineTwo_ff  <= lineTwo_ff | (colLast & lineFull_ff);
    end
  end

  // All three taps shift together, so one window is complete per pixel.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        winTop_ff[i] <= '0;
        winMid_ff[i] <= '0;
        winBot_ff[i] <= '0;
      end
    end else if (adv) begin
      winTop_ff[0] <= tapB;
      winMid_ff[0] <= tapA;
      winBot_ff[0] <= inPixel;
      for (int i = 1; i < 3; i++) begin
        winTop_ff[i] <= winTop_ff[i-1];
        winMid_ff[i] <= winMid_ff[i-1];
        winBot_ff[i] <= winBot_ff[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Gradient arithmetic
  // ---------------------------------------------------------------
  // Index 0 is the newest, rightmost column; index 2 the leftmost.
  // Taps sharing a weight are summed first: eight adders here.
  assign nxt_sums.right  = {2'h0, winTop_ff[0]} + {2'h0, winMid_ff[0]}
                         + {2'h0, winBot_ff[0]};
  assign nxt_sums.left   = {2'h0, winTop_ff[2]} + {2'h0, winMid_ff[2]}
                         + {2'h0, winBot_ff[2]};
  assign nxt_sums.top    = {2'h0, winTop_ff[0]} + {2'h0, winTop_ff[1]}
                         + {2'h0, winTop_ff[2]};
  assign nxt_sums.bottom = {2'h0, winBot_ff[0]} + {2'h0, winBot_ff[1]}
                         + {2'h0, winBot_ff[2]};
  // Two subtractors apply the +1 and -1 weights.
  assign nxt_gradX = $signed({1'b0, sums_ff.right}) -
                     $signed({1'b0, sums_ff.left});
  assign nxt_gradY = $signed({1'b0, sums_ff.top}) -
                     $signed({1'b0, sums_ff.bottom});
  // Ninth adder merges the magnitudes.
  assign rawStr    = {1'b0, absX_ff} + {1'b0, absY_ff};
  assign scaledStr = rawStr >> SCALE_SHIFT;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v0_ff    <= 1'b0;
      v1_ff    <= 1'b0;
      v2_ff    <= 1'b0;
      v3_ff    <= 1'b0;
      v4_ff    <= 1'b0;
      sums_ff  <= '0;
      gradX_ff <= '0;
      gradY_ff <= '0;
      absX_ff  <= '0;
      absY_ff  <= '0;
      res_ff   <= '0;
      thrQ_ff  <= '0;
    end else if (adv) begin
      v0_ff    <= lineFull_ff;
      v1_ff    <= v0_ff;
      v2_ff    <= v1_ff;
      v3_ff    <= v2_ff;
      v4_ff    <= v3_ff;
      sums_ff  <= nxt_sums;
      gradX_ff <= nxt_gradX;
      gradY_ff <= nxt_gradY;
      absX_ff  <= absVal(gradX_ff);
      absY_ff  <= absVal(gradY_ff);
      res_ff.strength <= scaledStr;
      res_ff.isEdge   <= scaledStr > threshold;
      thrQ_ff  <= threshold;
    end
  end

  // ---------------------------------------------------------------
  // Two-entry output buffer
  // ---------------------------------------------------------------
  // Ready is registered; it only rises when a free entry is certain.
  assign nxt_count    = count_ff + {1'b0, push} - {1'b0, pop};
  assign headFromTail = pop & (count_ff == 2'h2);
  assign headFromPush = push & ((count_ff == 2'h0) | (pop & (count_ff == 2'h1)));
  assign tailLoad     = push & (((count_ff == 2'h1) & !pop) | (count_ff == 2'h2));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff    <= '0;
      outValid_ff <= 1'b0;
      inReady_ff  <= 1'b0;
      head_ff    <= '0;
      tail_ff    <= '0;
    end else begin
      count_ff    <= nxt_count;
      // Valid is kept in its own flop so the output comes straight from one.
      outValid_ff <= nxt_count != 2'h0;
      inReady_ff  <= nxt_count < `GEF_BUF_DEPTH;
      if (headFromTail) begin
        head_ff <= tail_ff;
      end else if (headFromPush) begin
        head_ff <= res_ff;
      end
      if (tailLoad) begin
        tail_ff <= res_ff;
      end
    end
  end

  assign inReady   = inReady_ff;
  assign outValid  = outValid_ff;
  assign outResult = head_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_taps_aligned: assert property (adv |=> winTop_ff[0] == $past(tapB) &&
      winMid_ff[0] == $past(tapA) && winBot_ff[0] == $past(inPixel))
    else $error("line buffer taps not aligned with input");

  a_col_wrap: assert property (adv && colLast |=> col_ff == '0)
    else $error("column counter did not wrap at line end");

  a_no_early_valid: assert property (!lineFull_ff |-> !v0_ff && !outValid)
    else $error("output valid before one full line");

  a_grad_formula: assert property (adv |=> gradX_ff ==
      $signed({1'b0, $past(sums_ff.right)}) - $signed({1'b0, $past(sums_ff.left)}))
    else $error("horizontal gradient wrong");

  a_abs_value: assert property (adv |=> absY_ff ==
      ($past(gradY_ff) < 0 ? -$past(gradY_ff) : $past(gradY_ff)))
    else $error("absolute value wrong");

  a_edge_thresh: assert property (res_ff.isEdge == (res_ff.strength > thrQ_ff))
    else $error("edge bit disagrees with threshold");

  a_strength_sum: assert property (adv |=> res_ff.strength ==
      gef_str_t'(({1'b0, $past(absX_ff)} + {1'b0, $past(absY_ff)}) >> SCALE_SHIFT))
    else $error("edge strength is not the sum of magnitudes");

  a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outResult))
    else $error("output changed while stalled");

  a_valid_count: assert property (outValid == (count_ff != 2'h0))
    else $error("output valid disagrees with buffer fill");

  a_count_bound: assert property (count_ff <= 2'h2)
    else $error("output buffer count out of range");

  a_stall_freeze: assert property (!adv |=> $stable(col_ff) && $stable(sums_ff))
    else $error("pipeline moved without an accepted pixel");

  a_top_zero: assert property (!lineTwo_ff |-> tapB == '0)
    else $error("top row tap not zero before two lines");

  a_col_sum: assert property (adv |=> sums_ff.right ==
      $past(winTop_ff[0]) + $past(winMid_ff[0]) + $past(winBot_ff[0]))
    else $error("right column sum wrong");

  a_grad_vert: assert property (adv |=> gradY_ff ==
      $signed({1'b0, $past(sums_ff.top)}) - $signed({1'b0, $past(sums_ff.bottom)}))
    else $error("vertical gradient wrong");

  a_abs_horiz: assert property (adv |=> absX_ff ==
      ($past(gradX_ff) < 0 ? -$past(gradX_ff) : $past(gradX_ff)))
    else $error("horizontal absolute value wrong");

  a_full_stall: assert property (count_ff == 2'h2 |-> !inReady)
    else $error("input accepted while buffer full");

  // Once v3_ff is set, the next accepted pixel sets v4_ff, the last valid stage, which lets results push.
  a_pipe_latency: assert property (adv && v3_ff |=> v4_ff)
    else $error("result not pushed after pipeline fill");

  c_first_line: cover property (adv && colLast && !lineFull_ff);
  c_result_out: cover property (outValid && outReady && outResult.isEdge);
  c_buffer_full: cover property (count_ff == 2'h2);
  c_stream_run: cover property ((push && pop) [*4]);
endmodule

// [hdl/gef_params.svh]
// Purpose: Constants of the streaming 3x3 gradient edge filter.
// Assumes: 8-bit grey pixels arriving in raster order on one clock.
// Notes:   Widths below are sized so that no sum can overflow.
// Operation
// - Each pixel passes through chained line buffers acting as delay lines.
// - Each line buffer is exactly one image line deep; a parameter sets it.
// - All line-buffer taps reach the filter array in the same cycle.
// - A square 3x3 window steps pixel by pixel, then line by line.
// - Weighted taps are summed in an adder tree for the centre pixel.
// - A scaling step is applied to the final summed output.
// - Pixels sharing one coefficient are added before the single weighting.
// - Coefficients are +1, -1, 0, so only adders and subtractors are used.
// - The gradient arithmetic uses nine adders and two subtractors.
// - Two orthogonal gradients, horizontal and vertical, use one shared window.
// - Both gradient results merge into one total edge strength.
// - Pixel is an edge when strength exceeds the threshold, else not.
// - Horizontal kernel: columns -1,0,1; vertical kernel: rows 1,0,-1.
// - Edge strength is the sum of both gradient absolute values.
// - Fully pipelined: one result per clock once running.
// - Output valid stays low until one full line is buffered.
`ifndef GEF_PARAMS_SVH
`define GEF_PARAMS_SVH
`define GEF_PIX_W       8
`define GEF_SUM_W       10
`define GEF_GRAD_W      11
`define GEF_STR_W       11
`define GEF_LINE_LEN    640
`define GEF_SCALE_SHIFT 0
`define GEF_CNT_W       2
`define GEF_BUF_DEPTH   2'h2
`endif

// [hdl/gef_pkg.sv]
// Purpose: Types shared by the gradient edge filter.
// Assumes: Widths come from gef_params.svh.
// Notes:   None.
`include "gef_params.svh"
package gef_pkg;
  typedef logic [`GEF_PIX_W-1:0]         gef_pix_t;
  typedef logic [`GEF_SUM_W-1:0]         gef_sum_t;
  typedef logic signed [`GEF_GRAD_W-1:0] gef_grad_t;
  typedef logic [`GEF_STR_W-1:0]         gef_str_t;
  typedef struct packed {
    gef_sum_t left;
    gef_sum_t right;
    gef_sum_t top;
    gef_sum_t bottom;
  } gef_colsum_t;
  typedef struct packed {
    gef_str_t strength;
    logic     isEdge;
  } gef_result_t;
endpackage

// [verification/gef_sink_model.sv]
// Purpose: Result consumer standing where the memory-side stream sink would be.
// Assumes: One clock shared with the filter; results are taken on outValid and outReady.
// Notes:   stallMode 0 takes every result, 1 stalls at random, 2 stalls for good.
`timescale 1ns/1ps
module gef_sink_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Stall control from the bench.
  input  wire logic [1:0] stallMode,
  // Result stream handshake.
  output logic            outReady
);
  logic outReady_ff;

  assign outReady = outReady_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outReady_ff <= 1'b0;
    end else begin
      case (stallMode)
        2'd0:    outReady_ff <= 1'b1;
        2'd1:    outReady_ff <= ($urandom % 3) != 0;
        default: outReady_ff <= 1'b0;
      endcase
    end
  end
endmodule

// [verification/gef_gradient_edge_filter_tb.sv]
// Purpose: Self-checking bench for the streaming gradient edge filter.
// Assumes: A short line length keeps the run brief; expectations use the same value.
// Notes:   Every accepted pixel and threshold is logged to rebuild each window.
`timescale 1ns/1ps
module gef_gradient_edge_filter_tb;
  import gef_pkg::*;
  localparam int L  = 4;
  localparam int SH = 0;
  logic        clk;
  logic        rst_n;
  logic        inValid;
  logic        inReady;
  logic        outValid;
  logic        outReady;
  logic        srcOn;
  logic        rst2;
  logic [1:0]  stallMode;
  gef_pix_t    inPixel;
  gef_str_t    threshold;
  gef_str_t    thrSet;
  gef_result_t outResult;
  int          mode;
  int          acc;
  int          rx;
  int          t0;
  int          failures;
  int          samplesChecked;
  gef_pix_t    pixQ[$];
  gef_str_t    thrQ[$];

  gef_gradient_edge_filter #(.LINE_LEN(L), .SCALE_SHIFT(SH)) gef_gradient_edge_filter_i (
    .clk(clk), .rst_n(rst_n), .inValid(inValid), .inReady(inReady), .inPixel(inPixel),
    .threshold(threshold), .outValid(outValid), .outReady(outReady), .outResult(outResult));

  gef_sink_model gef_sink_model_i (
    .clk(clk), .rst_n(rst_n), .stallMode(stallMode), .outReady(outReady));

  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  function automatic int px(int i);
    return (i < 0) ? 0 : int'(pixQ[i]);
  endfunction

  // Window whose newest pixel is n: rows n-2L, n-L, n and columns n-2..n.
  function automatic gef_result_t expRes(int n);
    int          gx;
    int          gy;
    int          s;
    gef_result_t r;
    gx = px(n - 2 * L) + px(n - L) + px(n) - px(n - 2 * L - 2) - px(n - L - 2) - px(n - 2);
    gy = px(n - 2 * L) + px(n - 2 * L - 1) + px(n - 2 * L - 2) - px(n) - px(n - 1) - px(n - 2);
    s = ((gx < 0 ? -gx : gx) + (gy < 0 ? -gy : gy)) >>> SH;
    r.strength = gef_str_t'(s);
    r.isEdge = s > int'(thrQ[n + 4]);
    return r;
  endfunction

  function automatic gef_pix_t gen(int k);
    case (mode)
      0:       return 8'h64;
      1:       return ((k / 2) % 2) ? 8'hff : 8'h00;
      default: return gef_pix_t'($urandom);
    endcase
  endfunction

  // Sink checking first, then the source, so both see one ordering.
  always @(posedge clk) begin
    if (outValid && outReady) begin
      if (!rst2 || rx >= L + 2) check(32'(outResult), 32'(expRes(L + rx)), "result");
      rx++;
    end
    if (outValid) check(32'(acc >= L + 6), 32'h1, "early valid");
    if (inValid && inReady) begin
      pixQ.push_back(inPixel);
      thrQ.push_back(threshold);
      acc++;
    end
    if (srcOn && (!inValid || inReady) && (mode != 2 || ($urandom % 5) != 0)) begin
      inValid <= 1'b1;
      inPixel <= gen(acc);
      threshold <= (mode == 2) ? gef_str_t'($urandom % 1600) : thrSet;
    end else if (inValid && inReady) begin
      inValid <= 1'b0;
    end
  end

  task automatic run(input int m, input gef_str_t t, input logic [1:0] s, input int n);
    mode = m;
    thrSet = t;
    stallMode = s;
    srcOn = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    $display("test done: mode %0d stall %0d cycles %0d", m, s, n);
  endtask

  task automatic drain();
    srcOn = 1'b0;
    stallMode = 2'd0;
    repeat (12) @(posedge clk);
    #1;
    check(32'(rx), 32'(acc - L - 5), "result count");
    $display("test done: drain, %0d results", rx);
  endtask

  task automatic results();
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The tests take under 1000 cycles; ten times that means a hang.
  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    inValid = 1'b0;
    inPixel = 8'h00;
    threshold = 11'h000;
    {thrSet, stallMode, srcOn, rst2} = '0;
    {mode, acc, rx, failures, samplesChecked} = '0;
    void'($urandom(50070));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    run(0, 11'h000, 2'd0, 6 * L);
    run(1, 11'h2fd, 2'd1, 8 * L);
    run(2, 11'h000, 2'd1, 300);
    run(0, 11'h3e8, 2'd2, 20);
    check(32'(inReady), 32'h0, "full buffer refuses");
    run(1, 11'h1ff, 2'd0, 8);
    t0 = rx;
    run(1, 11'h1fe, 2'd0, 32);
    check(32'(rx - t0), 32'd32, "one result per clock");
    drain();
    @(posedge clk) rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    pixQ.delete();
    thrQ.delete();
    acc = 0;
    rx = 0;
    rst2 = 1'b1;
    rst_n <= 1'b1;
    run(2, 11'h000, 2'd1, 100);
    drain();
    results();
  end
endmodule
